/* File: fbm_consts.vh */
`ifndef FBM_CONSTS_VH
`define FBM_CONSTS_VH

// -------------------------------------------------------------------
// clock and timing, nanoseconds as given, cycle counts derived
// -------------------------------------------------------------------
`define FBM_CLK_NS 10
`define FBM_T_CE_NS 100
`define FBM_T_WS_NS 10
`define FBM_T_WP_NS 50
`define FBM_T_WH_NS 10
`define FBM_T_WPH_NS 30
`define FBM_T_RP_NS 500
`define FBM_T_RH_NS 50
`define FBM_T_RDY_EMB_NS 20000
`define FBM_T_RDY_NEMB_NS 500

// least times round up
`define FBM_CYC_UP(ns) ((((ns) + `FBM_CLK_NS - 1) / `FBM_CLK_NS) < 1 ? 1 : \
    (((ns) + `FBM_CLK_NS - 1) / `FBM_CLK_NS))
// longest times round down
`define FBM_CYC_DN(ns) (((ns) / `FBM_CLK_NS) < 1 ? 1 : ((ns) / `FBM_CLK_NS))

`define FBM_CE_CYC `FBM_CYC_UP(`FBM_T_CE_NS)
`define FBM_WS_CYC `FBM_CYC_UP(`FBM_T_WS_NS)
`define FBM_WP_CYC `FBM_CYC_UP(`FBM_T_WP_NS)
`define FBM_WH_CYC `FBM_CYC_UP(`FBM_T_WH_NS)
`define FBM_WPH_CYC `FBM_CYC_UP(`FBM_T_WPH_NS)
`define FBM_RP_CYC `FBM_CYC_UP(`FBM_T_RP_NS)
`define FBM_RH_CYC `FBM_CYC_UP(`FBM_T_RH_NS)
`define FBM_RDY_EMB_CYC `FBM_CYC_DN(`FBM_T_RDY_EMB_NS)
`define FBM_RDY_NEMB_CYC `FBM_CYC_DN(`FBM_T_RDY_NEMB_NS)

// pin synchroniser latency (three stages plus agreement)
`define FBM_SYNC_CYC 4

// -------------------------------------------------------------------
// request operations
// -------------------------------------------------------------------
`define FBM_OP_READ 2'h0
`define FBM_OP_WRITE 2'h1
`define FBM_OP_FAST_PROG 2'h2
`define FBM_OP_RESET 2'h3

// -------------------------------------------------------------------
// bank decode of the top three word address bits
// -------------------------------------------------------------------
`define FBM_BANK_ONE 2'h0
`define FBM_BANK_TWO 2'h1
`define FBM_BANK_THREE 2'h2
`define FBM_BANK_FOUR 2'h3

`endif

/* File: fbm_pin_sync.v */
`timescale 1ns/1ps
`default_nettype none

module fbm_pin_sync #(
    parameter W = 33
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // pins in, settled levels out
    input wire [W-1:0] pin_in,
    output wire [W-1:0] lvl_out
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg lvl_reg;
            // a change counts once stages two and three agree
            always @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    lvl_reg <= 1'b0;
                end else begin
                    s1_reg <= pin_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end
            assign lvl_out[i] = lvl_reg;
        end
    endgenerate

endmodule // fbm_pin_sync

`default_nettype wire

/* File: fbm_host_ctrl.v */
// Operation
// - command writes drive write strobe and chip select low, output gate high
// - fast-program mode programs one unit in two write cycles
// - under accelerate voltage host uses only the two-cycle program
// - accelerate voltage never applied for other operations but fast program and reset
// - host flags in op_aborted any operation a reset interrupted, without restarting it
// - host waits reset-high recovery time before reading
`timescale 1ns/1ps
`default_nettype none
`include "fbm_consts.vh"

module fbm_host_ctrl #(
    parameter [31:0] FAST_CMD = 32'h0000_0000,
    parameter [15:0] RDY_EMB_CYC = `FBM_RDY_EMB_CYC
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // user request
    input wire req_valid,
    output wire req_ready,
    input wire [1:0] req_op,
    input wire [22:0] req_addr,
    input wire [31:0] req_data,
    input wire req_word,
    // user answer and status
    output reg rsp_valid,
    output reg [31:0] rsp_data,
    output reg [1:0] rsp_bank,
    output reg op_aborted,
    output wire dev_busy,
    input wire accel_req,
    // flash pins
    output reg [21:0] flash_addr,
    output reg chip_sel_n,
    output reg out_gate_n,
    output reg write_strobe_n,
    output reg width_sel,
    output reg hw_reset_n,
    output reg accel_program_pin,
    input wire done_busy_out,
    input wire [31:0] dq_in,
    output reg [31:0] dq_out,
    output wire [31:0] dq_oe
);

    // -------------------------------------------------------------------
    // states and counts
    // -------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_RD = 4'h1;
    localparam [3:0] ST_WR_SET = 4'h2;
    localparam [3:0] ST_WR_LOW = 4'h3;
    localparam [3:0] ST_WR_HOLD = 4'h4;
    localparam [3:0] ST_WR_GAP = 4'h5;
    localparam [3:0] ST_RST_LOW = 4'h6;
    localparam [3:0] ST_RST_RDY = 4'h7;
    localparam [3:0] ST_RST_REC = 4'h8;

    localparam [15:0] CE_CYC = `FBM_CE_CYC + `FBM_SYNC_CYC;
    localparam [15:0] WS_CYC = `FBM_WS_CYC;
    localparam [15:0] WP_CYC = `FBM_WP_CYC;
    localparam [15:0] WH_CYC = `FBM_WH_CYC;
    localparam [15:0] WPH_CYC = `FBM_WPH_CYC;
    localparam [15:0] RP_CYC = `FBM_RP_CYC;
    localparam [15:0] RH_CYC = `FBM_RH_CYC;
    localparam [15:0] NEMB_CYC = `FBM_RDY_NEMB_CYC;

    // -------------------------------------------------------------------
    // bank decode
    // -------------------------------------------------------------------
    function [1:0] bank_of;
        input [2:0] top;
        begin
            case (top)
                3'h0: bank_of = `FBM_BANK_ONE;
                3'h1, 3'h2, 3'h3: bank_of = `FBM_BANK_TWO;
                3'h4, 3'h5, 3'h6: bank_of = `FBM_BANK_THREE;
                default: bank_of = `FBM_BANK_FOUR;
            endcase
        end
    endfunction

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    wire [32:0] sync_lvl;
    wire ready_sync;
    wire [31:0] dq_sync;

    fbm_pin_sync #(.W(33)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({done_busy_out, dq_in}),
        .lvl_out(sync_lvl)
    );

    assign ready_sync = sync_lvl[32];
    assign dq_sync = sync_lvl[31:0];
    assign dev_busy = ~ready_sync;

    // -------------------------------------------------------------------
    // control state
    // -------------------------------------------------------------------
    reg [3:0] state_reg;
    reg [15:0] cnt_reg;
    reg fast_reg;
    reg phase_reg;
    reg [31:0] data_reg;
    reg half_lsb_reg;
    reg emb_reg;
    wire cnt_done;
    wire op_ok;
    wire drive_data;

    assign cnt_done = (cnt_reg == 16'h0001);

    assign op_ok = ~accel_program_pin | (req_op == `FBM_OP_FAST_PROG) |
        (req_op == `FBM_OP_RESET);
    assign req_ready = (state_reg == ST_IDLE) & op_ok &
        (accel_program_pin == accel_req);

    // word mode: line 31 carries half-word address, 30..16 float
    // data lines released whenever not writing, line 31 excepted in word-mode reads
    assign drive_data = (state_reg == ST_WR_SET) | (state_reg == ST_WR_LOW) |
        (state_reg == ST_WR_HOLD);
    assign dq_oe = width_sel ? {32{drive_data}} :
        {(state_reg == ST_RD) | drive_data, 15'h0000, {16{drive_data}}};

    // -------------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 16'h0000;
            fast_reg <= 1'b0;
            phase_reg <= 1'b0;
            data_reg <= 32'h0000_0000;
            half_lsb_reg <= 1'b0;
            emb_reg <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 32'h0000_0000;
            rsp_bank <= 2'h0;
            op_aborted <= 1'b0;
            flash_addr <= 22'h00_0000;
            chip_sel_n <= 1'b1;
            out_gate_n <= 1'b1;
            write_strobe_n <= 1'b1;
            width_sel <= 1'b1;
            hw_reset_n <= 1'b1;
            accel_program_pin <= 1'b0;
            dq_out <= 32'h0000_0000;
        end else begin
            rsp_valid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    chip_sel_n <= 1'b1;
                    out_gate_n <= 1'b1;
                    write_strobe_n <= 1'b1;
                    accel_program_pin <= accel_req;
                    if (req_valid && req_ready) begin
                        rsp_bank <= bank_of(req_addr[22:20]);
                        flash_addr <= req_addr[22:1];
                        half_lsb_reg <= req_addr[0];
                        width_sel <= ~req_word;
                        data_reg <= req_data;
                        fast_reg <= (req_op == `FBM_OP_FAST_PROG);
                        phase_reg <= 1'b0;
                        op_aborted <= 1'b0;
                        case (req_op)
                            `FBM_OP_READ: begin
                                chip_sel_n <= 1'b0;
                                out_gate_n <= 1'b0;
                                cnt_reg <= CE_CYC;
                                state_reg <= ST_RD;
                            end
                            `FBM_OP_RESET: begin
                                hw_reset_n <= 1'b0;
                                emb_reg <= ~ready_sync;
                                op_aborted <= ~ready_sync;
                                cnt_reg <= RP_CYC;
                                state_reg <= ST_RST_LOW;
                            end
                            default: begin
                                // fast program opens with its command word
                                dq_out <= (req_op == `FBM_OP_FAST_PROG) ?
                                    FAST_CMD : req_data;
                                chip_sel_n <= 1'b0;
                                cnt_reg <= WS_CYC;
                                state_reg <= ST_WR_SET;
                            end
                        endcase
                        // half-word address steady from the first select
                        if (req_word) begin
                            dq_out[31] <= req_addr[0];
                        end
                    end
                end
                ST_RD: begin
                    if (cnt_done) begin
                        rsp_data <= width_sel ? dq_sync : {16'h0000, dq_sync[15:0]};
                        rsp_valid <= 1'b1;
                        chip_sel_n <= 1'b1;
                        out_gate_n <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                ST_WR_SET: begin
                    if (cnt_done) begin
                        // strobe falls after select: address latched here
                        write_strobe_n <= 1'b0;
                        cnt_reg <= WP_CYC;
                        state_reg <= ST_WR_LOW;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                ST_WR_LOW: begin
                    if (cnt_done) begin
                        // strobe rises first: data latched here
                        write_strobe_n <= 1'b1;
                        cnt_reg <= WH_CYC;
                        state_reg <= ST_WR_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                ST_WR_HOLD: begin
                    if (cnt_done) begin
                        chip_sel_n <= 1'b1;
                        cnt_reg <= WPH_CYC;
                        state_reg <= ST_WR_GAP;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                ST_WR_GAP: begin
                    if (!cnt_done) begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end else if (fast_reg && !phase_reg) begin
                        // second cycle carries the program data
                        phase_reg <= 1'b1;
                        dq_out <= data_reg;
                        chip_sel_n <= 1'b0;
                        cnt_reg <= WS_CYC;
                        state_reg <= ST_WR_SET;
                    end else begin
                        rsp_valid <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RST_LOW: begin
                    if (cnt_done) begin
                        hw_reset_n <= 1'b1;
                        // ready time depends on busy at reset
                        cnt_reg <= emb_reg ? RDY_EMB_CYC : NEMB_CYC;
                        state_reg <= ST_RST_RDY;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                ST_RST_RDY: begin
                    // after an embedded abort wait for busy to clear, bounded by ready time; otherwise wait the whole ready time
                    if (cnt_done || (emb_reg && ready_sync)) begin
                        cnt_reg <= RH_CYC;
                        state_reg <= ST_RST_REC;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                ST_RST_REC: begin
                    // recovery before next access; flag stands
                    if (cnt_done) begin
                        rsp_valid <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            // line 31 carries the half-word address in word mode
            if (!width_sel && state_reg != ST_IDLE) begin
                dq_out[31] <= half_lsb_reg;
            end
        end
    end

endmodule // fbm_host_ctrl

`default_nettype wire

/* File: fbm_host_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbm_consts.vh"

module fbm_host_ctrl_checker (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // user side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [1:0] req_op,
    input wire logic rsp_valid,
    // flash pins
    input wire logic chip_sel_n,
    input wire logic out_gate_n,
    input wire logic write_strobe_n,
    input wire logic width_sel,
    input wire logic hw_reset_n,
    input wire logic accel_program_pin,
    input wire logic [31:0] dq_out,
    input wire logic [31:0] dq_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // -------------------------------------------------------------------
    // helper: length of the reset pulse so far
    // -------------------------------------------------------------------
    logic [15:0] low_cnt_reg;
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            low_cnt_reg <= 16'h0000;
        else
            low_cnt_reg <= hw_reset_n ? 16'h0000 : low_cnt_reg + 16'h0001;

    // -------------------------------------------------------------------
    // properties
    // -------------------------------------------------------------------
    sequence s_strobe_pulse;
        (!write_strobe_n)[*5];
    endsequence
    sequence s_data_edge;
        write_strobe_n && !chip_sel_n;
    endsequence
    property p_wr_qual;
        !write_strobe_n |-> !chip_sel_n && out_gate_n;
    endproperty
    property p_wr_edges;
        $fell(write_strobe_n) |-> !$past(chip_sel_n) ##0 s_strobe_pulse ##1 s_data_edge;
    endproperty
    property p_data_hold;
        !write_strobe_n |-> $stable(dq_out);
    endproperty
    property p_read_qual;
        !out_gate_n |-> write_strobe_n && !chip_sel_n;
    endproperty
    property p_word_lines;
        !width_sel && !chip_sel_n |-> dq_oe[30:16] == 15'h0000;
    endproperty
    property p_rst_width;
        $rose(hw_reset_n) |-> low_cnt_reg >= `FBM_RP_CYC;
    endproperty
    property p_recovery;
        $rose(hw_reset_n) |-> (out_gate_n && chip_sel_n)[*5];
    endproperty
    property p_rst_quiet;
        !hw_reset_n |-> chip_sel_n && out_gate_n && write_strobe_n && dq_oe == 32'h0000_0000;
    endproperty
    property p_accel_idle;
        $changed(accel_program_pin) |-> chip_sel_n && hw_reset_n;
    endproperty
    property p_accel_no_read;
        accel_program_pin |-> out_gate_n;
    endproperty
    property p_read_answer;
        req_valid && req_ready && req_op == 2'h0 |-> ##[13:16] rsp_valid;
    endproperty

    a_wr_qual: assert property (p_wr_qual) else $error("strobe low outside a write");
    a_wr_edges: assert property (p_wr_edges) else $error("strobe edges out of order");
    a_data_hold: assert property (p_data_hold) else $error("write data moved");
    a_read_qual: assert property (p_read_qual) else $error("gate low outside a read");
    a_word_lines: assert property (p_word_lines) else $error("upper lines driven");
    a_rst_width: assert property (p_rst_width) else $error("reset pulse too short");
    a_recovery: assert property (p_recovery) else $error("read too soon after reset");
    a_rst_quiet: assert property (p_rst_quiet) else $error("bus active in reset");
    a_accel_idle: assert property (p_accel_idle) else $error("accel moved mid cycle");
    a_accel_no_read: assert property (p_accel_no_read) else $error("read under accel");
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
endmodule // fbm_host_ctrl_checker

bind fbm_host_ctrl fbm_host_ctrl_checker u_chk (
    .clk, .sys_rst, .req_valid, .req_ready, .req_op, .rsp_valid, .chip_sel_n, .out_gate_n,
    .write_strobe_n, .width_sel, .hw_reset_n, .accel_program_pin, .dq_out, .dq_oe
);
`default_nettype wire

/* File: fbm_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none

module fbm_flash_model #(
    parameter logic [31:0] FAST_CMD = 32'h0000_0000,
    parameter logic [31:0] ERASE_CMD = 32'h0000_0030,
    parameter int CE_NS = 90,
    parameter int BUSY_NS = 300,
    parameter int RDY_NS = 150
) (
    // host driven pins
    input wire logic [21:0] flash_addr,
    input wire logic chip_sel_n,
    input wire logic out_gate_n,
    input wire logic write_strobe_n,
    input wire logic width_sel,
    input wire logic hw_reset_n,
    input wire logic accel_program_pin,
    input wire logic [31:0] dq_out,
    // device driven pins
    output logic done_busy_out,
    output logic [31:0] dq_in
);
    logic [31:0] mem [0:7];
    logic [31:0] pend, wd, nxt;
    logic [2:0] widx, pidx;
    logic in_wr, armed, bypass, run, hold;
    realtime t_chg;

    initial begin
        for (int i = 0; i < 8; i++)
            mem[i] = 32'hC3C3_0000 + i;
        {in_wr, armed, run, hold} = 4'h0;
        bypass = 1'b1;
        dq_in = 32'h0000_0000;
        t_chg = 0;
    end

    // width select picks unit and half-word line
    wire [2:0] cur = {flash_addr[1:0], width_sel ? 1'b0 : dq_out[31]};

    always @(negedge write_strobe_n or negedge chip_sel_n)
        if (!write_strobe_n && !chip_sel_n && out_gate_n && hw_reset_n) begin
            widx = cur;
            in_wr = 1'b1;
        end

    // data on the earlier rise, two cycle program
    always @(posedge write_strobe_n or posedge chip_sel_n)
        if (in_wr && hw_reset_n) begin
            in_wr = 1'b0;
            wd = width_sel ? dq_out : {16'h0000, dq_out[15:0]};
            // erase word clears the addressed unit, the smallest scope
            if (wd == ERASE_CMD)
                mem[widx] = 32'hFFFF_FFFF;
            if (armed && !run) begin
                pend = wd;
                pidx = widx;
                run = 1'b1;
            end
            armed = !armed && (bypass || accel_program_pin) && wd == FAST_CMD;
        end

    always @(posedge run) begin
        #(BUSY_NS);
        if (run)
            mem[pidx] = pend;
        run = 1'b0;
    end

    // reset aborts, leaves fast mode, busy held if embedded
    always @(negedge hw_reset_n) begin
        hold = run;
        run = 1'b0;
        armed = 1'b0;
        bypass = 1'b0;
        in_wr = 1'b0;
        #(RDY_NS);
        hold = 1'b0;
    end
    assign done_busy_out = !(run || hold);

    // access time from last change, data held while stable
    always @(chip_sel_n or flash_addr or cur or hw_reset_n)
        t_chg = $realtime;

    // lines toggle unless selected, gated, out of reset, not busy and past access time; 31..16 always toggle in word mode
    always #5 begin
        nxt = ~dq_in;
        if (!chip_sel_n && !out_gate_n && hw_reset_n && !run && $realtime - t_chg >= CE_NS) begin
            nxt[15:0] = mem[cur][15:0];
            if (width_sel)
                nxt[31:16] = mem[cur][31:16];
        end
        dq_in = nxt;
    end
endmodule // fbm_flash_model
`default_nettype wire

/* File: fbm_host_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbm_consts.vh"

module fbm_host_ctrl_bench;
    // arbitrary command word
    localparam logic [31:0] FAST = 32'h0000_00A0;
    localparam logic [31:0] ERASE = 32'h0000_0030;
    localparam logic [22:0] A0 = {3'h3, 17'h0, 2'h0, 1'b0};
    typedef struct packed {
        logic [1:0] op;
        logic acc;
        logic w;
        logic [22:0] a;
        logic [31:0] d;
        logic [1:0] b;
    } fbm_row_t;
    fbm_row_t rows [0:8] = '{
        '{2'h0, 1'b0, 1'b0, {3'h0, 17'h0, 2'h3, 1'b0}, 32'hC3C3_0006, 2'h0},
        '{2'h2, 1'b0, 1'b0, {3'h1, 17'h0, 2'h1, 1'b0}, 32'h1357_9BDF, 2'h1},
        '{2'h0, 1'b0, 1'b0, {3'h1, 17'h0, 2'h1, 1'b0}, 32'h1357_9BDF, 2'h1},
        '{2'h2, 1'b1, 1'b0, {3'h4, 17'h0, 2'h2, 1'b0}, 32'h2468_ACE0, 2'h2},
        '{2'h0, 1'b0, 1'b0, {3'h6, 17'h0, 2'h2, 1'b0}, 32'h2468_ACE0, 2'h2},
        '{2'h2, 1'b0, 1'b1, {3'h7, 17'h0, 2'h0, 1'b1}, 32'h0000_BEEF, 2'h3},
        '{2'h0, 1'b0, 1'b1, {3'h7, 17'h0, 2'h0, 1'b1}, 32'h0000_BEEF, 2'h3},
        '{2'h1, 1'b0, 1'b0, {3'h5, 17'h0, 2'h3, 1'b0}, ERASE, 2'h2},
        '{2'h0, 1'b0, 1'b0, {3'h5, 17'h0, 2'h3, 1'b0}, 32'hFFFF_FFFF, 2'h2}
    };
    logic clk, sys_rst, req_valid, req_ready, req_word, rsp_valid, op_aborted, dev_busy;
    logic accel_req, chip_sel_n, out_gate_n, write_strobe_n, width_sel, hw_reset_n;
    logic accel_program_pin, done_busy_out;
    logic [1:0] req_op, rsp_bank;
    logic [21:0] flash_addr;
    logic [22:0] req_addr;
    logic [31:0] req_data, rsp_data, dq_in, dq_out, dq_oe;
    int miscompares = 0;
    int comparisons = 0;

    fbm_host_ctrl #(.FAST_CMD(FAST), .RDY_EMB_CYC(16'h0014)) u_dut (
        .clk, .sys_rst, .req_valid, .req_ready, .req_op, .req_addr, .req_data, .req_word,
        .rsp_valid, .rsp_data, .rsp_bank, .op_aborted, .dev_busy, .accel_req, .flash_addr,
        .chip_sel_n, .out_gate_n, .write_strobe_n, .width_sel, .hw_reset_n,
        .accel_program_pin, .done_busy_out, .dq_in, .dq_out, .dq_oe
    );
    fbm_flash_model #(.FAST_CMD(FAST), .ERASE_CMD(ERASE)) u_flash (
        .flash_addr, .chip_sel_n, .out_gate_n, .write_strobe_n, .width_sel, .hw_reset_n,
        .accel_program_pin, .dq_out, .done_busy_out, .dq_in
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // -------------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // k: 0 ready, 1 answer, 2 busy
    task automatic wait_for(input int k, input logic lvl);
        int n;
        n = 0;
        while ((k == 0 ? req_ready : k == 1 ? rsp_valid : dev_busy) !== lvl) begin
            @(negedge clk);
            n++;
            if (n > 4000) begin
                miscompares++;
                $display("FAIL %0t wait ran out", $time);
                tally_and_finish();
            end
        end
    endtask

    task automatic issue(input logic [1:0] op, input logic [22:0] a, input logic [31:0] d,
                         input logic w, input logic settle);
        req_op = op;
        req_addr = a;
        req_data = d;
        req_word = w;
        // let ready settle on the new request before testing it
        @(negedge clk);
        wait_for(0, 1'b1);
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        wait_for(1, 1'b1);
        if (settle) begin
            repeat (6) @(negedge clk);
            wait_for(2, 1'b0);
        end
    endtask

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        {req_valid, req_word, accel_req, req_op, req_addr, req_data} = '0;
        sys_rst = 1'b1;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            accel_req = rows[i].acc;
            issue(rows[i].op, rows[i].a, rows[i].d, rows[i].w, 1'b1);
            if (rows[i].op == `FBM_OP_READ)
                check(rsp_data, rows[i].d);
            check({30'h0, rsp_bank}, {30'h0, rows[i].b});
            $display("row %0d done", i);
        end
        accel_req = 1'b1;
        req_op = `FBM_OP_READ;
        repeat (4) @(negedge clk);
        check({31'h0, req_ready}, 32'h0000_0000);
        accel_req = 1'b0;
        $display("accel refusal test done");
        issue(`FBM_OP_FAST_PROG, A0, 32'h0F0F_0F0F, 1'b0, 1'b0);
        repeat (6) @(negedge clk);
        check({31'h0, dev_busy}, 32'h0000_0001);
        issue(`FBM_OP_RESET, A0, 32'h0, 1'b0, 1'b1);
        check({31'h0, op_aborted}, 32'h0000_0001);
        issue(`FBM_OP_READ, A0, 32'h0, 1'b0, 1'b1);
        check(rsp_data, 32'hC3C3_0000);
        check({30'h0, rsp_bank}, 32'h0000_0001);
        issue(`FBM_OP_FAST_PROG, A0, 32'h0F0F_0F0F, 1'b0, 1'b1);
        issue(`FBM_OP_READ, A0, 32'h0, 1'b0, 1'b1);
        check(rsp_data, 32'hC3C3_0000);
        accel_req = 1'b1;
        issue(`FBM_OP_FAST_PROG, A0, 32'h0F0F_0F0F, 1'b0, 1'b1);
        accel_req = 1'b0;
        issue(`FBM_OP_READ, A0, 32'h0, 1'b0, 1'b1);
        check(rsp_data, 32'h0F0F_0F0F);
        $display("reset during program test done");
        issue(`FBM_OP_RESET, A0, 32'h0, 1'b0, 1'b1);
        check({31'h0, op_aborted}, 32'h0000_0000);
        $display("idle reset test done");
        tally_and_finish();
    end
endmodule // fbm_host_ctrl_bench
`default_nettype wire
